// ---- hw/quad_sram_sweep_tester.sv ----
// Four-channel SRAM write-then-verify sweep tester
`timescale 1ns/1ns
`include "sweep_params.svh"

module quad_sram_sweep_tester
  import sweep_pkg::*;
#(
  parameter int unsigned WORDS = `SWEEP_WORDS
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic button_n_in,
  input wire logic ref_cfg_done_in,
  input wire logic [`CHANNELS-1:0] ctrl_ready_in,
  input wire mm_rsp_s [`CHANNELS-1:0] mm_rsp_in,
  output mm_req_s [`CHANNELS-1:0] mm_req_out,
  output logic ref_cfg_req_out,
  output logic result_lamp_a_out,
  output logic result_lamp_b_out,
  output logic result_lamp_c_out,
  output logic result_lamp_d_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Copies of one LFSR word needed to fill a memory word
  localparam int unsigned REP = (`WORD_W + `LFSR_W - 1) / `LFSR_W;
  // Counters carry a spare bit, so a sweep of the full address space
  // can still name its last word without wrapping to zero
  localparam logic [`ADDR_W:0] LAST =
    (`ADDR_W+1)'(WORDS - 1);

  // Maximal-length taps 32,22,2,1; never reaches the all-zero lock
  function automatic logic [`LFSR_W-1:0] lfsr_step(
    input logic [`LFSR_W-1:0] v);
    lfsr_step = {v[`LFSR_W-2:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Widen one LFSR word to a memory word by replication
  function automatic logic [`WORD_W-1:0] pattern(
    input logic [`LFSR_W-1:0] v);
    logic [REP*`LFSR_W-1:0] wide;
    wide = {REP{v}};
    pattern = wide[`WORD_W-1:0];
  endfunction

  // ---------------------------------------------------------------
  // Button synchroniser and lamp drive
  // ---------------------------------------------------------------
  top_s top_ff;
  top_s nxt_top;
  // One bit per channel, each driven from its own generate slice
  wire logic [`CHANNELS-1:0] chan_pass;
  wire logic [`CHANNELS-1:0] chan_fail;
  logic go;

  // reference clocks ready before start
  // Keep asking the clock configurator until it reports done
  assign ref_cfg_req_out = ~ref_cfg_done_in;

  // Button level only moves when the last two stages agree
  // A bounce shorter than two samples never reaches btn_up
  always_comb begin
    nxt_top = top_ff;
    nxt_top.btn_sync = {top_ff.btn_sync[1:0], button_n_in};
    if (top_ff.btn_sync[2] == top_ff.btn_sync[1]) begin
      nxt_top.btn_up = top_ff.btn_sync[2];
    end
    nxt_top.lamp = top_ff.btn_up ? (chan_pass & ~chan_fail) : '0;
  end

  // Reset reads as button held, so no pass starts until the pin
  // has been seen released for two samples
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      top_ff <= '0;
    end else begin
      top_ff <= nxt_top;
    end
  end

  // button starts every tester
  // Testers also wait for the reference clocks to reach the user rate
  assign go = top_ff.btn_up & ref_cfg_done_in;

  // lamp order A to D
  // Lamps come straight from flops, so they never glitch
  assign result_lamp_a_out = top_ff.lamp[0];
  assign result_lamp_b_out = top_ff.lamp[1];
  assign result_lamp_c_out = top_ff.lamp[2];
  assign result_lamp_d_out = top_ff.lamp[3];

  // ---------------------------------------------------------------
  // Per-channel testers
  // ---------------------------------------------------------------
  // user side runs on the half-rate clock
  // clk_in is the controller user clock; no crossing is needed
  genvar ch;
  generate
    for (ch = 0; ch < `CHANNELS; ch++) begin : g_chan
      // Each slice is a whole tester with its own counters and pattern
      chan_s cs_ff;
      chan_s nxt_cs;
      mm_rsp_s rsp;
      logic beat_ok;

      assign rsp = mm_rsp_in[ch];
      assign chan_pass[ch] = cs_ff.pass;
      assign chan_fail[ch] = cs_ff.fail;
      assign beat_ok = ~rsp.waitrequest;

      // requests go only to this channel port
      // Data comes straight from state flops, so it is glitch-free
      always_comb begin
        mm_req_out[ch].write = (cs_ff.st == CH_WRITE);
        mm_req_out[ch].read = (cs_ff.st == CH_READ);
        mm_req_out[ch].address = (cs_ff.st == CH_READ) ?
          cs_ff.rd_issued[`ADDR_W-1:0] : cs_ff.wr_cnt[`ADDR_W-1:0];
        mm_req_out[ch].writedata = pattern(cs_ff.wr_lfsr);
      end

      // Sequencer, compare and result flags
      always_comb begin
        nxt_cs = cs_ff;
        // Returns are matched in issue order; a controller that reorders
        // them would show up as a miscompare
        // verify stream advances per returned word
        if ((cs_ff.st == CH_READ || cs_ff.st == CH_DRAIN) &&
            rsp.readdatavalid) begin
          if (rsp.readdata != pattern(cs_ff.rd_lfsr)) begin
            nxt_cs.fail = 1'b1;
          end
          nxt_cs.rd_lfsr = lfsr_step(cs_ff.rd_lfsr);
          nxt_cs.rd_done = cs_ff.rd_done + 1'b1;
        end
        case (cs_ff.st)
          CH_IDLE: begin
            nxt_cs.wr_cnt = '0;
            nxt_cs.rd_issued = '0;
            nxt_cs.rd_done = '0;
            nxt_cs.wr_lfsr = `LFSR_SEED;
            nxt_cs.rd_lfsr = `LFSR_SEED;
            nxt_cs.fail = 1'b0;
            nxt_cs.pass = 1'b0;
            if (go && ctrl_ready_in[ch]) begin
              nxt_cs.st = CH_WRITE;
            end
          end
          CH_WRITE: begin
            // A stalled beat keeps address and data steady until taken
            // sweep covers every word
            if (beat_ok) begin
              nxt_cs.wr_cnt = cs_ff.wr_cnt + 1'b1;
              nxt_cs.wr_lfsr = lfsr_step(cs_ff.wr_lfsr);
              // reads begin after the last write
              if (cs_ff.wr_cnt == LAST) begin
                nxt_cs.st = CH_READ;
              end
            end
          end
          CH_READ: begin
            if (beat_ok) begin
              nxt_cs.rd_issued = cs_ff.rd_issued + 1'b1;
              if (cs_ff.rd_issued == LAST) begin
                nxt_cs.st = CH_DRAIN;
              end
            end
          end
          CH_DRAIN: begin
            // No new requests here; only the last returns are awaited
            // pass only after complete verify
            if (rsp.readdatavalid && cs_ff.rd_done == LAST) begin
              nxt_cs.st = CH_DONE;
              nxt_cs.pass = 1'b1;
            end
          end
          CH_DONE: begin
            // Result holds until the button is pressed again
            nxt_cs.st = CH_DONE;
          end
          default: begin
            nxt_cs.st = CH_IDLE;
          end
        endcase
        // a press aborts and rearms the pass
        // A miscompare on the same edge keeps its flag; IDLE clears it
        // one cycle later, so no event is half recorded
        if (!top_ff.btn_up) begin
          nxt_cs.st = CH_IDLE;
          nxt_cs.pass = 1'b0;
        end
      end

      // Reset parks the tester in IDLE with both flags clear
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          cs_ff <= '{st: CH_IDLE, default: '0};
        end else begin
          cs_ff <= nxt_cs;
        end
      end
    end
  endgenerate

endmodule

// ---- hw/sweep_params.svh ----
// Constants for the quad SRAM sweep tester
`ifndef SWEEP_PARAMS_SVH
`define SWEEP_PARAMS_SVH

// ---------------------------------------------------------------
// Clock plan
// ---------------------------------------------------------------
`define MEM_CLK_MHZ 550
`define USER_CLK_MHZ 275
`define REF_CLK_DEFAULT_KHZ 166667
`define REF_CLK_TARGET_MHZ 275

// ---------------------------------------------------------------
// Memory geometry and sweep
// ---------------------------------------------------------------
`define CAPACITY_MBIT 144
`define WORD_W 72
`define ADDR_W 21
`define SWEEP_WORDS ((`CAPACITY_MBIT * 1024 * 1024) / `WORD_W)
`define CHANNELS 4

// ---------------------------------------------------------------
// Pattern generator and button synchroniser
// ---------------------------------------------------------------
`define LFSR_W 32
`define LFSR_SEED 32'hACE1_2468
`define BTN_SYNC_W 3

`endif

// ---- hw/sweep_pkg.sv ----
// Types shared by the quad SRAM sweep tester
`include "sweep_params.svh"

package sweep_pkg;

  // Tester sequencing per channel
  typedef enum logic [2:0] {
    CH_IDLE,
    CH_WRITE,
    CH_READ,
    CH_DRAIN,
    CH_DONE
  } chan_state_e;

  // Request toward one controller user port
  typedef struct packed {
    logic write;
    logic read;
    logic [`ADDR_W-1:0] address;
    logic [`WORD_W-1:0] writedata;
  } mm_req_s;

  // Answer from one controller user port
  typedef struct packed {
    logic waitrequest;
    logic readdatavalid;
    logic [`WORD_W-1:0] readdata;
  } mm_rsp_s;

  // Per-channel tester state
  typedef struct packed {
    chan_state_e st;
    logic [`ADDR_W:0] wr_cnt;
    logic [`ADDR_W:0] rd_issued;
    logic [`ADDR_W:0] rd_done;
    logic [`LFSR_W-1:0] wr_lfsr;
    logic [`LFSR_W-1:0] rd_lfsr;
    logic fail;
    logic pass;
  } chan_s;

  // Shared front-end state
  typedef struct packed {
    logic [`BTN_SYNC_W-1:0] btn_sync;
    logic btn_up;
    logic [`CHANNELS-1:0] lamp;
  } top_s;

endpackage

// ---- tb/sram_port_model.sv ----
// Behavioural controller user port for one SRAM channel
`timescale 1ns/1ns
`include "sweep_params.svh"
module sram_port_model
  import sweep_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic slow_in,
  input wire logic bad_in,
  input wire mm_req_s req_in,
  output mm_rsp_s rsp_out
);
  logic [`WORD_W-1:0] mem [16];
  logic [`WORD_W-1:0] dat_ff;
  logic hold_ff;
  logic vld_ff;
  logic take;
  assign take = req_in.read & ~hold_ff;
  assign rsp_out = '{hold_ff, vld_ff, dat_ff};
  // Slow mode stalls every other cycle; bad flips one bit of word 5
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hold_ff <= 1'b0;
      vld_ff <= 1'b0;
      dat_ff <= '0;
    end else begin
      hold_ff <= slow_in & ~hold_ff;
      vld_ff <= take;
      if (req_in.write & ~hold_ff)
        mem[req_in.address[3:0]] <= req_in.writedata;
      // Idle bus toggles so a stale word never looks valid
      dat_ff <= take ? mem[req_in.address[3:0]] ^
        {71'h0, bad_in && req_in.address[3:0] == 4'h5} : ~dat_ff;
    end
  end
endmodule

// ---- tb/quad_sram_sweep_tester_asserts.sv ----
// Port-level checks for the quad SRAM sweep tester
`timescale 1ns/1ns
`include "sweep_params.svh"
module quad_sram_sweep_tester_asserts
  import sweep_pkg::*;
#(
  parameter int unsigned WORDS = 16
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic button_n_in,
  input wire logic ref_cfg_done_in,
  input wire logic [`CHANNELS-1:0] ctrl_ready_in,
  input wire mm_rsp_s [`CHANNELS-1:0] mm_rsp_in,
  input wire mm_req_s [`CHANNELS-1:0] mm_req_out,
  input wire logic ref_cfg_req_out,
  input wire logic result_lamp_a_out,
  input wire logic result_lamp_b_out,
  input wire logic result_lamp_c_out,
  input wire logic result_lamp_d_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Write beat taken on channel D
  sequence s_wbeat;
    mm_req_out[3].write && !mm_rsp_in[3].waitrequest;
  endsequence
  // Write held off on channel A
  sequence s_stall;
    mm_req_out[0].write && mm_rsp_in[0].waitrequest;
  endsequence
  // Button released long enough that no abort is pending
  sequence s_btn_up;
    button_n_in [*5];
  endsequence
  property p_dark;
    !button_n_in [*6] |-> !(result_lamp_a_out | result_lamp_b_out |
      result_lamp_c_out | result_lamp_d_out);
  endproperty
  a_dark: assert property (p_dark) else $error("lamp lit");
  property p_cfg;
    ref_cfg_req_out == !ref_cfg_done_in;
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg request");
  property p_gate;
    !ref_cfg_done_in |=> !$rose(mm_req_out[0].write);
  endproperty
  a_gate: assert property (p_gate) else $error("early start");
  property p_ready;
    !ctrl_ready_in[1] |=> !$rose(mm_req_out[1].write);
  endproperty
  a_ready: assert property (p_ready) else $error("not ready");
  property p_span;
    mm_req_out[2].write || mm_req_out[2].read |->
      mm_req_out[2].address < WORDS;
  endproperty
  a_span: assert property (p_span) else $error("address range");
  property p_wseq;
    s_wbeat ##1 mm_req_out[3].write |->
      mm_req_out[3].address == $past(mm_req_out[3].address) + 1'b1;
  endproperty
  a_wseq: assert property (p_wseq) else $error("address step");
  property p_stall;
    s_btn_up ##0 s_stall |=> mm_req_out[0].write &&
      $stable(mm_req_out[0].address) && $stable(mm_req_out[0].writedata);
  endproperty
  a_stall: assert property (p_stall) else $error("stall drop");
  property p_rd;
    $rose(mm_req_out[1].read) |->
      mm_req_out[1].address == 0 && $past(mm_req_out[1].write);
  endproperty
  a_rd: assert property (p_rd) else $error("read start");
  property p_lamp;
    $rose(result_lamp_b_out) |-> !mm_req_out[1].read && !mm_req_out[1].write;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp early");
endmodule
bind quad_sram_sweep_tester
  quad_sram_sweep_tester_asserts #(.WORDS(WORDS)) u_chk (
  .clk_in(clk_in), .resetn_in(resetn_in), .button_n_in(button_n_in),
  .ref_cfg_done_in(ref_cfg_done_in), .ctrl_ready_in(ctrl_ready_in),
  .mm_rsp_in(mm_rsp_in), .mm_req_out(mm_req_out),
  .ref_cfg_req_out(ref_cfg_req_out), .result_lamp_a_out(result_lamp_a_out),
  .result_lamp_b_out(result_lamp_b_out), .result_lamp_c_out(result_lamp_c_out),
  .result_lamp_d_out(result_lamp_d_out));

// ---- tb/quad_sram_sweep_tester_tb.sv ----
// Self-checking bench for the quad SRAM sweep tester
`timescale 1ns/1ns
module quad_sram_sweep_tester_tb;
  import sweep_pkg::*;
  logic clk_in = 0, resetn_in = 0, button_n_in = 1, ref_cfg_done_in = 1;
  logic [3:0] ctrl_ready_in = 4'hF, slow = 4'h0, bad = 4'h0, lamps;
  mm_rsp_s [3:0] rsp;
  mm_req_s [3:0] req;
  logic cfg_req;
  int fail_count = 0, tests_run = 0;
  // Rows: stall mask, corrupt mask, expected lamps
  logic [11:0] rows [4] = '{12'h00F, 12'h52D, 12'h087, 12'hF1E};
  quad_sram_sweep_tester #(.WORDS(16)) dut (.clk_in(clk_in),
    .resetn_in(resetn_in), .button_n_in(button_n_in),
    .ref_cfg_done_in(ref_cfg_done_in), .ctrl_ready_in(ctrl_ready_in),
    .mm_rsp_in(rsp), .mm_req_out(req), .ref_cfg_req_out(cfg_req),
    .result_lamp_a_out(lamps[0]), .result_lamp_b_out(lamps[1]),
    .result_lamp_c_out(lamps[2]), .result_lamp_d_out(lamps[3]));
  // One port model per channel
  for (genvar i = 0; i < 4; i++) begin : g_ch
    sram_port_model m (.clk_in(clk_in), .resetn_in(resetn_in),
      .slow_in(slow[i]), .bad_in(bad[i]), .req_in(req[i]), .rsp_out(rsp[i]));
  end
  initial forever #25 clk_in = ~clk_in;
  task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Hold the button long enough to pass the synchroniser
  task automatic press;
    @(posedge clk_in) button_n_in <= 0;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in) check("lamps held", lamps, 4'h0);
    @(posedge clk_in) button_n_in <= 1;
  endtask
  // A failing lamp never lights, so the wait is bounded; a few more
  // cycles let a wrongly lit late lamp show before the compare
  task automatic wait_lamps(logic [3:0] exp);
    for (int n = 0; n < 300 && lamps !== exp; n++) begin
      @(negedge clk_in);
    end
    repeat (4) @(negedge clk_in);
    check("lamps", lamps, exp);
  endtask
  task automatic run(logic [3:0] exp);
    press();
    wait_lamps(exp);
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    resetn_in <= 1;
    foreach (rows[r]) begin
      @(posedge clk_in);
      slow <= rows[r][11:8];
      bad <= rows[r][7:4];
      run(rows[r][3:0]);
    end
    // Abort mid-write, then a fresh pass
    @(posedge clk_in);
    slow <= 4'h0;
    bad <= 4'h0;
    press();
    repeat (12) @(posedge clk_in);
    run(4'hF);
    // System reset mid-write: requests drop, then a pass starts alone
    press();
    repeat (12) @(posedge clk_in);
    resetn_in <= 0;
    @(negedge clk_in) check("write reset", {3'h0, req[3].write}, 4'h0);
    @(posedge clk_in) resetn_in <= 1;
    wait_lamps(4'hF);
    @(posedge clk_in);
    ctrl_ready_in <= 4'hD;
    run(4'hD);
    // Reference clocks not set: nothing may start
    @(posedge clk_in);
    ctrl_ready_in <= 4'hF;
    ref_cfg_done_in <= 0;
    run(4'h0);
    repeat (100) @(negedge clk_in);
    check("lamps cfg", lamps, 4'h0);
    check("cfg req", {3'h0, cfg_req}, 4'h1);
    stop_test();
  end
  initial begin
    #(50 * 5000);
    fail_count++;
    stop_test();
  end
endmodule
